// ==== shared/ieu_params.svh ====
`ifndef IEU_PARAMS_SVH
`define IEU_PARAMS_SVH
`define IEU_NODES 27
`define IEU_EXT 8
`define IEU_CHANS 8
`define IEU_N_T2 5'h08
`define IEU_N_TXBUF 5'h11
`define IEU_N_RX 5'h12
`define IEU_N_XP0 5'h17
`define IEU_CH_WIDX 3'h1
`define IEU_OVF_ADDR 10'h100
`define IEU_UNF_ADDR 10'h104
`define IEU_TFR_ADDR 10'h108
`define IEU_STAT_ADDR 10'h10C
`define IEU_F_REQ 0
`define IEU_F_EN 1
`define IEU_F_PRIO 2
`define IEU_F_ETC 6
`define IEU_F_CH 7
`define IEU_F_EDGE 10
`define IEU_F_WORD 0
`define IEU_F_INCDST 1
`define IEU_F_CONT 2
`define IEU_F_CNT 8
`define IEU_F_STAT_REQ 8
`define IEU_OVF_RST 16'h0000
`define IEU_UNF_RST 16'hFFFF
`define IEU_TRAP_EXT0 7'h18
`define IEU_TRAP_T2 7'h22
`define IEU_TRAP_TXBUF 7'h47
`define IEU_TRAP_RX 7'h2B
`define IEU_TRAP_XP0 7'h40
`define IEU_TRAP_STACK_OVERFLOW_LIMIT 7'h04
`define IEU_TRAP_STACK_UNDERFLOW_LIMIT 7'h06
`endif

// ==== shared/ieu_pkg.sv ====
`default_nettype none
package ieu_pkg;
	typedef enum logic {ARB_IDLE, ARB_WAIT} ieu_arb_t;
	typedef logic [3:0] ieu_prio_t;
	typedef logic [6:0] ieu_trap_t;
endpackage : ieu_pkg
`default_nettype wire

// ==== core/ieu_core.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "ieu_params.svh"
module ieu_core
	import ieu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] ext_irq_pin,
	input wire logic [18:0] periph_req,
	input wire logic [3:0] cpu_level,
	input wire logic cpu_irq_ack,
	input wire logic stk_access,
	input wire logic [15:0] stack_pointer_reg,
	input wire logic trap_instr,
	input wire logic [6:0] trap_instr_num,
	output logic irq_req,
	output logic [6:0] irq_trap_num,
	output logic [15:0] irq_vector,
	output logic [3:0] irq_level,
	output logic xfer_req,
	output logic [15:0] xfer_src,
	output logic [15:0] xfer_dst,
	output logic xfer_word,
	output logic [2:0] xfer_chan,
	output logic trap_take,
	output logic trap_hw,
	output logic [6:0] trap_num,
	output logic [15:0] trap_vector
);
	function automatic ieu_trap_t node_trap(input logic [4:0] n);
		if (n < `IEU_N_T2)
			node_trap = 7'(`IEU_TRAP_EXT0 + n);
		else if (n < `IEU_N_TXBUF)
			node_trap = 7'(`IEU_TRAP_T2 + n - `IEU_N_T2);
		else if (n == `IEU_N_TXBUF)
			node_trap = `IEU_TRAP_TXBUF;
		else if (n < `IEU_N_XP0)
			node_trap = 7'(`IEU_TRAP_RX + n - `IEU_N_RX);
		else
			node_trap = 7'(`IEU_TRAP_XP0 + n - `IEU_N_XP0);
	endfunction : node_trap

	function automatic logic [15:0] trap_vec(input ieu_trap_t t);
		trap_vec = {7'h00, t, 2'b00};
	endfunction : trap_vec

	logic hreadyout_q, hresp_q, wr_q, rd_q;
	logic [9:0] addr_q;
	logic [31:0] hrdata_q, rd_d;
	logic [`IEU_NODES-1:0] req_q, en_q, etc_q, evt;
	ieu_prio_t prio_q [`IEU_NODES];
	logic [2:0] chan_q [`IEU_NODES];
	logic [1:0] edge_q [`IEU_EXT];
	logic ch_word_q [`IEU_CHANS];
	logic ch_incdst_q [`IEU_CHANS];
	logic ch_cont_q [`IEU_CHANS];
	logic [7:0] ch_cnt_q [`IEU_CHANS];
	logic [15:0] ch_src_q [`IEU_CHANS];
	logic [15:0] ch_dst_q [`IEU_CHANS];
	logic [15:0] ovf_q, unf_q;
	logic [1:0] tflag_q;
	logic [7:0] s1_q, s2_q, s3_q, stab_q, agree, ext_evt;
	ieu_arb_t arb_q;
	logic [4:0] held_idx_q, best_idx;
	ieu_prio_t best_lvl;
	logic found, do_xfer, xfer_last, ack_clr, ovf_hit, unf_hit;
	logic irq_req_q, xfer_req_q, xfer_word_q, trap_take_q, trap_hw_q;
	logic [6:0] irq_trap_q, trap_num_q;
	logic [15:0] irq_vec_q, xfer_src_q, xfer_dst_q, trap_vec_q;
	logic [3:0] irq_level_q;
	logic [2:0] xfer_chan_q, xc;

	wire logic acc = hsel && htrans[1] && hready;
	wire logic [7:0] wa = addr_q[9:2];
	wire logic node_hit = wa < 8'(`IEU_NODES);
	wire logic ch_hit = wa[7:5] == `IEU_CH_WIDX;
	wire logic [2:0] ch_i = wa[4:2];
	wire logic [1:0] ch_r = wa[1:0];
	wire logic [4:0] node_sel = wa[4:0];
	wire logic wr_node = wr_q && node_hit;

	// reads take one wait state so a write in the preceding data phase is always seen
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 10'h000;
			hrdata_q <= 32'h00000000;
		end else begin
			wr_q <= acc && hwrite;
			if (acc)
				addr_q <= haddr[9:0];
			if (acc && !hwrite) begin
				hreadyout_q <= 1'b0;
				rd_q <= 1'b1;
			end else if (rd_q) begin
				hreadyout_q <= 1'b1;
				rd_q <= 1'b0;
				hrdata_q <= rd_d;
			end
		end
	end

	always_comb begin
		rd_d = 32'h00000000;
		if (node_hit) begin
			rd_d[`IEU_F_REQ] = req_q[node_sel];
			rd_d[`IEU_F_EN] = en_q[node_sel];
			rd_d[`IEU_F_PRIO +: 4] = prio_q[node_sel];
			rd_d[`IEU_F_ETC] = etc_q[node_sel];
			rd_d[`IEU_F_CH +: 3] = chan_q[node_sel];
			if (node_sel < `IEU_N_T2)
				rd_d[`IEU_F_EDGE +: 2] = edge_q[node_sel[2:0]];
		end else if (ch_hit) begin
			unique case (ch_r)
				2'h0: begin
					rd_d[`IEU_F_WORD] = ch_word_q[ch_i];
					rd_d[`IEU_F_INCDST] = ch_incdst_q[ch_i];
					rd_d[`IEU_F_CONT] = ch_cont_q[ch_i];
					rd_d[`IEU_F_CNT +: 8] = ch_cnt_q[ch_i];
				end
				2'h1: rd_d[15:0] = ch_src_q[ch_i];
				2'h2: rd_d[15:0] = ch_dst_q[ch_i];
				default: rd_d = 32'h00000000;
			endcase
		end else begin
			unique case (addr_q)
				`IEU_OVF_ADDR: rd_d[15:0] = ovf_q;
				`IEU_UNF_ADDR: rd_d[15:0] = unf_q;
				`IEU_TFR_ADDR: rd_d[1:0] = tflag_q;
				`IEU_STAT_ADDR: begin
					rd_d[4:0] = held_idx_q;
					rd_d[`IEU_F_STAT_REQ] = irq_req_q;
				end
				default: rd_d = 32'h00000000;
			endcase
		end
	end

	// a pin change is believed only once the second and third stages agree
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s1_q <= 8'h00;
			s2_q <= 8'h00;
			s3_q <= 8'h00;
			stab_q <= 8'h00;
		end else begin
			s1_q <= ext_irq_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stab_q <= (agree & s3_q) | (~agree & stab_q);
		end
	end

	always_comb begin
		agree = ~(s2_q ^ s3_q);
		for (int i = 0; i < `IEU_EXT; i++)
			ext_evt[i] = agree[i] && (s3_q[i] != stab_q[i]) &&
				((s3_q[i] && edge_q[i][0]) || (!s3_q[i] && edge_q[i][1]));
		evt = {periph_req, ext_evt};
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_q <= '0;
			etc_q <= '0;
			for (int i = 0; i < `IEU_NODES; i++) begin
				prio_q[i] <= 4'h0;
				chan_q[i] <= 3'h0;
			end
			for (int i = 0; i < `IEU_EXT; i++)
				edge_q[i] <= 2'h0;
		end else if (wr_node) begin
			en_q[node_sel] <= hwdata[`IEU_F_EN];
			prio_q[node_sel] <= hwdata[`IEU_F_PRIO +: 4];
			etc_q[node_sel] <= hwdata[`IEU_F_ETC];
			chan_q[node_sel] <= hwdata[`IEU_F_CH +: 3];
			if (node_sel < `IEU_N_T2)
				edge_q[node_sel[2:0]] <= hwdata[`IEU_F_EDGE +: 2];
		end
	end

	// a hardware event beats a same-cycle clear by write or by acceptance
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			req_q <= '0;
		else
			for (int i = 0; i < `IEU_NODES; i++) begin
				if (wr_node && node_sel == 5'(i))
					req_q[i] <= hwdata[`IEU_F_REQ];
				if ((ack_clr && held_idx_q == 5'(i)) || (do_xfer && !xfer_last && best_idx == 5'(i)))
					req_q[i] <= 1'b0;
				if (evt[i])
					req_q[i] <= 1'b1;
			end
	end

	// ties between equal levels go to the lowest node index
	always_comb begin
		found = 1'b0;
		best_idx = 5'h00;
		best_lvl = 4'h0;
		for (int i = 0; i < `IEU_NODES; i++)
			if (req_q[i] && en_q[i] && prio_q[i] > cpu_level && (!found || prio_q[i] > best_lvl)) begin
				found = 1'b1;
				best_idx = 5'(i);
				best_lvl = prio_q[i];
			end
		xc = chan_q[best_idx];
		do_xfer = arb_q == ARB_IDLE && found && etc_q[best_idx] &&
			(ch_cont_q[xc] || ch_cnt_q[xc] != 8'h00);
		xfer_last = !ch_cont_q[xc] && ch_cnt_q[xc] == 8'h01;
		ack_clr = arb_q == ARB_WAIT && cpu_irq_ack;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			arb_q <= ARB_IDLE;
			irq_req_q <= 1'b0;
			held_idx_q <= 5'h00;
			irq_level_q <= 4'h0;
			irq_trap_q <= 7'h00;
			irq_vec_q <= 16'h0000;
		end else begin
			unique case (arb_q)
				ARB_IDLE: if (found && !do_xfer) begin
					arb_q <= ARB_WAIT;
					irq_req_q <= 1'b1;
					held_idx_q <= best_idx;
					irq_level_q <= best_lvl;
					irq_trap_q <= node_trap(best_idx);
					irq_vec_q <= trap_vec(node_trap(best_idx));
				end
				ARB_WAIT: if (cpu_irq_ack) begin
					arb_q <= ARB_IDLE;
					irq_req_q <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			for (int c = 0; c < `IEU_CHANS; c++) begin
				ch_word_q[c] <= 1'b0;
				ch_incdst_q[c] <= 1'b0;
				ch_cont_q[c] <= 1'b0;
				ch_cnt_q[c] <= 8'h00;
				ch_src_q[c] <= 16'h0000;
				ch_dst_q[c] <= 16'h0000;
			end
		end else begin
			for (int c = 0; c < `IEU_CHANS; c++) begin
				if (wr_q && ch_hit && ch_i == 3'(c)) begin
					unique case (ch_r)
						2'h0: begin
							ch_word_q[c] <= hwdata[`IEU_F_WORD];
							ch_incdst_q[c] <= hwdata[`IEU_F_INCDST];
							ch_cont_q[c] <= hwdata[`IEU_F_CONT];
							ch_cnt_q[c] <= hwdata[`IEU_F_CNT +: 8];
						end
						2'h1: ch_src_q[c] <= hwdata[15:0];
						2'h2: ch_dst_q[c] <= hwdata[15:0];
						default: ;
					endcase
				end
				if (do_xfer && xc == 3'(c)) begin
					if (ch_incdst_q[c])
						ch_dst_q[c] <= ch_dst_q[c] + {14'h0000, ch_word_q[c], !ch_word_q[c]};
					else
						ch_src_q[c] <= ch_src_q[c] + {14'h0000, ch_word_q[c], !ch_word_q[c]};
					if (!ch_cont_q[c])
						ch_cnt_q[c] <= ch_cnt_q[c] - 8'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			xfer_req_q <= 1'b0;
			xfer_src_q <= 16'h0000;
			xfer_dst_q <= 16'h0000;
			xfer_word_q <= 1'b0;
			xfer_chan_q <= 3'h0;
		end else begin
			xfer_req_q <= do_xfer;
			xfer_src_q <= ch_src_q[xc];
			xfer_dst_q <= ch_dst_q[xc];
			xfer_word_q <= ch_word_q[xc];
			xfer_chan_q <= xc;
		end
	end

	assign ovf_hit = stk_access && stack_pointer_reg < ovf_q;
	assign unf_hit = stk_access && stack_pointer_reg > unf_q;

	// stack faults outrank a trap instruction in the same cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ovf_q <= `IEU_OVF_RST;
			unf_q <= `IEU_UNF_RST;
			tflag_q <= 2'h0;
			trap_take_q <= 1'b0;
			trap_hw_q <= 1'b0;
			trap_num_q <= 7'h00;
			trap_vec_q <= 16'h0000;
		end else begin
			if (wr_q && addr_q == `IEU_OVF_ADDR)
				ovf_q <= hwdata[15:0];
			if (wr_q && addr_q == `IEU_UNF_ADDR)
				unf_q <= hwdata[15:0];
			tflag_q <= (tflag_q & ~((wr_q && addr_q == `IEU_TFR_ADDR) ? hwdata[1:0] : 2'h0)) |
				{unf_hit, ovf_hit};
			trap_take_q <= ovf_hit || unf_hit || trap_instr;
			trap_hw_q <= ovf_hit || unf_hit;
			if (ovf_hit) begin
				trap_num_q <= `IEU_TRAP_STACK_OVERFLOW_LIMIT;
				trap_vec_q <= trap_vec(`IEU_TRAP_STACK_OVERFLOW_LIMIT);
			end else if (unf_hit) begin
				trap_num_q <= `IEU_TRAP_STACK_UNDERFLOW_LIMIT;
				trap_vec_q <= trap_vec(`IEU_TRAP_STACK_UNDERFLOW_LIMIT);
			end else begin
				trap_num_q <= trap_instr_num;
				trap_vec_q <= trap_vec(trap_instr_num);
			end
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign irq_req = irq_req_q;
	assign irq_trap_num = irq_trap_q;
	assign irq_vector = irq_vec_q;
	assign irq_level = irq_level_q;
	assign xfer_req = xfer_req_q;
	assign xfer_src = xfer_src_q;
	assign xfer_dst = xfer_dst_q;
	assign xfer_word = xfer_word_q;
	assign xfer_chan = xfer_chan_q;
	assign trap_take = trap_take_q;
	assign trap_hw = trap_hw_q;
	assign trap_num = trap_num_q;
	assign trap_vector = trap_vec_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	a_xfer_no_branch: assert property (xfer_req |-> !$rose(irq_req)) else $error("transfer with branch");
	a_preempt_level: assert property ($rose(irq_req) |->
		irq_level > $past(cpu_level)) else $error("level not higher");
	a_vector_scale: assert property (irq_req |->
		irq_vector == {7'h00, irq_trap_num, 2'b00}) else $error("vector mismatch");
	a_ext_trap: assert property (irq_req && held_idx_q < 5'h08 |->
		irq_trap_num == 7'(7'h18 + held_idx_q)) else $error("ext trap");
	a_txbuf_trap: assert property (irq_req && held_idx_q == 5'h11 |->
		irq_vector == 16'h011C) else $error("txbuf vector");
	a_ack_release: assert property (irq_req && cpu_irq_ack |=> !irq_req) else $error("ack ignored");
	a_latency: assert property (arb_q == ARB_IDLE && found && !do_xfer |=>
		irq_req) else $error("late response");
	a_stack_trap: assert property (ovf_hit |=>
		trap_take && trap_hw && trap_num == 7'h04 && tflag_q[0]) else $error("no ovf trap");
	a_unf_flag: assert property (unf_hit && !ovf_hit |=>
		trap_take && trap_hw && trap_vector == 16'h0018 && tflag_q[1]) else $error("no unf trap");
	a_count_dec: assert property (do_xfer && !ch_cont_q[xc] && !wr_q |=>
		ch_cnt_q[$past(xc)] == $past(ch_cnt_q[xc]) - 8'h01) else $error("count");
	a_sw_trap: assert property (trap_instr && !stk_access |=>
		trap_take && trap_num == $past(trap_instr_num)) else $error("sw trap");

	c_xfer: cover property (xfer_req && ch_cont_q[xfer_chan]);
	c_irq_ack: cover property (irq_req && cpu_irq_ack);
	// the parked flag wins arbitration one edge after the last transfer
	c_last_xfer: cover property (do_xfer && xfer_last ##2 irq_req);
	c_stack: cover property (trap_take && trap_hw);
endmodule : ieu_core
`default_nettype wire

// ==== test/ieu_cpu_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// cpu side: accepts a request after a short think time, then runs at that level until told the service ended
module ieu_cpu_model
	import ieu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic irq_req,
	input wire ieu_prio_t irq_level,
	input wire logic svc_done,
	output logic cpu_irq_ack,
	output ieu_prio_t cpu_level
);
	logic [1:0] wait_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wait_q <= 2'h0;
			cpu_irq_ack <= 1'b0;
			cpu_level <= 4'h0;
		end else begin
			// never ack twice: the request only drops one edge after the ack
			cpu_irq_ack <= irq_req && !cpu_irq_ack && wait_q == 2'h2;
			wait_q <= (irq_req && !cpu_irq_ack) ? wait_q + 2'h1 : 2'h0;
			if (cpu_irq_ack) begin
				cpu_level <= irq_level;
			end else if (svc_done) begin
				cpu_level <= 4'h0;
			end
		end
	end
endmodule : ieu_cpu_model
`default_nettype wire

// ==== test/tb_interrupt_and_event_transfer_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_and_event_transfer_unit
	import ieu_pkg::*;
;
	logic clk_sys = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic stk_access = 1'b0, trap_instr = 1'b0, svc_done = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2, xfer_chan;
	logic [7:0] ext_irq_pin = 8'h00;
	logic [18:0] periph_req = 19'h0;
	logic [15:0] stack_pointer_reg = 16'h0, irq_vector, xfer_src, xfer_dst, trap_vector;
	logic [6:0] trap_instr_num = 7'h00, irq_trap_num, trap_num;
	logic hreadyout, hresp, cpu_irq_ack, irq_req, xfer_req, xfer_word, trap_take, trap_hw;
	ieu_prio_t cpu_level, irq_level;
	int errors = 0, samples_checked = 0;
	always #50 clk_sys = ~clk_sys;
	ieu_core DUT (.clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
		.hrdata, .hreadyout, .hresp, .ext_irq_pin, .periph_req, .cpu_level, .cpu_irq_ack, .stk_access,
		.stack_pointer_reg, .trap_instr, .trap_instr_num, .irq_req, .irq_trap_num, .irq_vector, .irq_level,
		.xfer_req, .xfer_src, .xfer_dst, .xfer_word, .xfer_chan, .trap_take, .trap_hw, .trap_num, .trap_vector);
	ieu_cpu_model u_cpu (.clk_sys, .sys_rst, .irq_req, .irq_level, .svc_done, .cpu_irq_ack, .cpu_level);
	task automatic finish_test();
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		rd = hrdata;
	endtask : ahb
	task automatic pulse(input logic [18:0] m);
		periph_req <= m;
		@(posedge clk_sys);
		periph_req <= 19'h0;
	endtask : pulse
	// hold keeps the cpu at the accepted level so lower requests stay parked
	task automatic wait_irq(input logic [6:0] tn, input logic hold);
		int i;
		for (i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge clk_sys);
		chk(32'(irq_req), 32'h1);
		chk(32'(irq_trap_num), 32'(tn));
		chk(32'(irq_vector), {23'h0, tn, 2'h0});
		for (i = 0; i < 10 && irq_req === 1'b1; i++) @(posedge clk_sys);
		if (!hold) begin
			svc_done <= 1'b1;
			@(posedge clk_sys);
			svc_done <= 1'b0;
		end
	endtask : wait_irq
	// irq_exp: the count ran out, so the source's own interrupt follows the transfer
	task automatic wait_xfer(input logic [15:0] s, input logic [15:0] d, input logic [3:0] wc, input logic irq_exp);
		int i;
		for (i = 0; i < 10 && xfer_req !== 1'b1; i++) @(posedge clk_sys);
		chk({xfer_src, xfer_dst}, {s, d});
		chk(32'({xfer_req, xfer_word, xfer_chan}), {27'h0, 1'b1, wc});
		@(posedge clk_sys);
		chk(32'({xfer_req, irq_req}), 32'({1'b0, irq_exp}));
	endtask : wait_xfer
	task automatic trap_case(input logic instr, input logic [15:0] v, input logic hw, input logic [6:0] tn);
		int i;
		trap_instr <= instr;
		trap_instr_num <= v[6:0];
		stk_access <= !instr;
		stack_pointer_reg <= v;
		@(posedge clk_sys);
		trap_instr <= 1'b0;
		stk_access <= 1'b0;
		for (i = 0; i < 5 && trap_take !== 1'b1; i++) @(posedge clk_sys);
		chk(32'({trap_take, trap_hw, trap_num, trap_vector}), {7'h0, 1'b1, hw, tn, 7'h0, tn, 2'h0});
	endtask : trap_case
	initial begin
		#(100 * 5000);
		errors++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		ahb(0, 32'h100, 0); chk(rd, 32'h0000);
		ahb(0, 32'h104, 0); chk(rd, 32'hFFFF);
		ahb(0, 32'h1F0, 0); chk({rd[30:0], hresp}, 32'h0);
		ahb(1, 32'h44, 32'h0E);
		ahb(0, 32'h44, 0); chk(rd, 32'h0E);
		pulse(19'h1 << 9);
		wait_irq(7'h47, 0);
		ahb(0, 32'h44, 0); chk(rd, 32'h0E);
		ahb(1, 32'h28, 32'h14);
		pulse(19'h1 << 2);
		repeat (6) @(posedge clk_sys);
		chk(32'(irq_req), 32'h0);
		ahb(0, 32'h28, 0); chk(rd, 32'h15);
		// a control write rewrites the request bit too, so keep it set
		ahb(1, 32'h28, 32'h17);
		wait_irq(7'h24, 0);
		ahb(1, 32'h20, 32'h12);
		ahb(1, 32'h24, 32'h26);
		pulse(19'h3);
		wait_irq(7'h23, 1);
		repeat (6) @(posedge clk_sys);
		chk(32'({irq_req, cpu_level}), 32'h9);
		svc_done <= 1'b1;
		@(posedge clk_sys);
		svc_done <= 1'b0;
		wait_irq(7'h22, 0);
		ahb(1, 32'h50, 32'h0B);
		wait_irq(7'h2D, 0);
		ahb(1, 32'h00, 32'h406);
		ext_irq_pin[0] <= 1'b1;
		wait_irq(7'h18, 0);
		ahb(1, 32'h1C, 32'h806);
		ext_irq_pin[7] <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk(32'(irq_req), 32'h0);
		ext_irq_pin[7] <= 1'b0;
		wait_irq(7'h1F, 0);
		ahb(1, 32'h04, 32'hC06);
		ext_irq_pin[1] <= 1'b1;
		wait_irq(7'h19, 0);
		ext_irq_pin[1] <= 1'b0;
		wait_irq(7'h19, 0);
		// word channel, two services, then the count hits zero
		ahb(1, 32'h94, 32'h1000);
		ahb(1, 32'h98, 32'h2000);
		ahb(1, 32'h90, 32'h201);
		ahb(1, 32'h48, 32'hCA);
		pulse(19'h1 << 10);
		wait_xfer(16'h1000, 16'h2000, 4'h9, 1'b0);
		pulse(19'h1 << 10);
		wait_xfer(16'h1002, 16'h2000, 4'h9, 1'b1);
		wait_irq(7'h2B, 0);
		ahb(0, 32'h90, 0); chk(rd, 32'h001);
		ahb(1, 32'hA4, 32'h3000);
		ahb(1, 32'hA8, 32'h4000);
		ahb(1, 32'hA0, 32'h106);
		ahb(1, 32'h4C, 32'h14A);
		pulse(19'h1 << 11);
		wait_xfer(16'h3000, 16'h4000, 4'h2, 1'b0);
		pulse(19'h1 << 11);
		wait_xfer(16'h3000, 16'h4001, 4'h2, 1'b0);
		ahb(0, 32'hA0, 0); chk(rd, 32'h106);
		ahb(1, 32'h100, 32'h0100);
		trap_case(0, 16'h00FE, 1, 7'h04);
		ahb(0, 32'h108, 0); chk(rd, 32'h1);
		ahb(1, 32'h108, 32'h1);
		ahb(0, 32'h108, 0); chk(rd, 32'h0);
		ahb(1, 32'h104, 32'h8000);
		trap_case(0, 16'h9000, 1, 7'h06);
		trap_case(1, 16'h007F, 0, 7'h7F);
		finish_test();
	end
endmodule : tb_interrupt_and_event_transfer_unit
`default_nettype wire
